// ---- hdl/mbsl_pkg.sv ----
package mbsl_pkg;

    // Register offsets on the plain register port (byte addresses).
    localparam logic [7:0] ADDR_STATION  = 8'h00;
    localparam logic [7:0] ADDR_BAUD     = 8'h04;
    localparam logic [7:0] ADDR_ACCESS   = 8'h08;
    localparam logic [7:0] ADDR_GAPLIM   = 8'h0c;
    localparam logic [7:0] ADDR_REPLY    = 8'h10;
    localparam logic [7:0] ADDR_PASSCODE = 8'h14;
    localparam logic [7:0] ADDR_RECOVERY = 8'h18;
    localparam logic [7:0] ADDR_RESTORE  = 8'h1c;
    localparam logic [7:0] ADDR_FLOWCOEF = 8'h20;
    localparam logic [7:0] ADDR_TOTCOEF  = 8'h24;
    localparam logic [7:0] ADDR_BATCOEF  = 8'h28;
    localparam logic [7:0] ADDR_CURRENT  = 8'h2c;
    localparam logic [7:0] ADDR_STATUS   = 8'h30;
    localparam logic [7:0] ADDR_MASK     = 8'h34;
    localparam logic [7:0] ADDR_SCALED   = 8'h38;
    localparam logic [7:0] ADDR_NORM     = 8'h3c;
    localparam logic [7:0] ADDR_ALERT    = 8'h40;

    // Station address limits and broadcast alias.
    localparam logic [7:0] STATION_MAX   = 8'hc7;
    localparam logic [7:0] STATION_ALIAS = 8'hff;
    localparam logic [7:0] STATION_RST   = 8'h01;

    // Registers 04h and 05h always writable over the link; first configuration register.
    localparam logic [15:0] REG_OPEN_A = 16'h0004;
    localparam logic [15:0] REG_OPEN_B = 16'h0005;
    localparam logic [15:0] CFG_FIRST  = 16'h0000;

    localparam logic [6:0] GAP_MAX = 7'h63;

    // Factory restore code 5465 and blank passcode, in BCD.
    localparam logic [15:0] RESTORE_CODE  = 16'h5465;
    localparam logic [15:0] PASSCODE_NONE = 16'h0000;
    // Recovery code value is arbitrary.
    localparam logic [15:0] RECOVERY_CODE = 16'h7391;

    // Status bit positions.
    localparam int ST_FRAME   = 0;
    localparam int ST_ALERT   = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_RESTORE = 3;
    localparam int ST_W       = 4;

    // Timing: 100 MHz clock, one second.
    localparam longint CLK_HZ     = 100000000;
    localparam int     SECOND_CYC = 32'(CLK_HZ);
    localparam int     BITS_CHAR  = 11;

    typedef enum logic [2:0] {
        BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600,
        BAUD_19200, BAUD_38400, BAUD_57600, BAUD_115200
    } mbsl_baud_e;

    typedef enum logic [2:0] {
        REPLY_DELAY_SELECT_STD, REPLY_DELAY_SELECT_10, REPLY_DELAY_SELECT_20, REPLY_DELAY_SELECT_50, REPLY_DELAY_SELECT_100, REPLY_DELAY_SELECT_200
    } mbsl_reply_delay_select_e;

    // Parsed frame from the receiver.
    typedef struct packed {
        logic [7:0]  station;
        logic        isWrite;
        logic [15:0] regIndex;
        logic [15:0] data;
    } mbsl_frame_s;

    // Decision handed to the reply side.
    typedef struct packed {
        logic        accept;
        logic        writeOk;
        logic [15:0] regIndex;
        logic [15:0] data;
    } mbsl_reply_s;

endpackage

// ---- hdl/mbsl_link_supervisor.sv ----
// Function
// - Station address 0..199 is kept; frames matching it are answered.
// - With station zero, frames addressed to 255 are answered.
// - Line rate is one of eight values; master uses the same rate.
// - Remote writes to configuration registers are refused when permit off.
// - Registers 04h and 05h stay remotely writable regardless of permit.
// - Frame gap beyond 0..99 s limit drives remote outputs to alert.
// - Gap limit zero disables frame-gap supervision entirely.
// - Reply waits none, 10, 20, 50, 100 or 200 character times.
// - Passcode is four BCD digits; recovery code clears it, then dies.
// - Passcode zero disables menu passcode protection.
// - Four per-relay flags permit threshold edits without the passcode.
// - Restore needs code 5465, then confirm restores and cancel abandons.
// - Flow, total and batch each scale by their own coefficient.
// - Normalized input is (current minus range start) over range width.
// - Normalized result is not clamped outside the nominal range.
//
// Implementation choices: the register offsets and the plain strobed port.
module mbsl_link_supervisor (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic [7:0]            regAddr,
    input  wire logic [31:0]           regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [31:0]           regRdata,
    input  wire logic                  frameValid,
    input  wire mbsl_pkg::mbsl_frame_s frameIn,
    output mbsl_pkg::mbsl_reply_s      replyOut,
    output logic                       replyValid,
    output logic                       baudTick,
    output logic                       remoteAlert,
    output logic                       passcodeNeeded,
    output logic      [3:0]            thresholdEditOpen,
    output logic                       factoryRestore,
    input  wire logic                  keyConfirm,
    input  wire logic                  keyCancel,
    input  wire logic [15:0]           measuredValue,
    output logic      [31:0]           flowScaled,
    output logic      [31:0]           totalScaled,
    output logic      [31:0]           batchScaled,
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  station_r;
    logic [2:0]  baudSel_r;
    logic        remote_config_write_permit_r;
    logic [3:0]  threshold_edit_permit_r;
    logic [6:0]  frame_gap_limit_r;
    logic [2:0]  reply_delay_select_r;
    logic [15:0] user_passcode_r;
    logic        recoveryUsed_r;
    logic        restoreArmed_r;
    logic [15:0] flow_scale_factor_r;
    logic [15:0] total_scale_factor_r;
    logic [15:0] batch_scale_factor_r;
    logic        range420_r;
    localparam int ST_W_L = mbsl_pkg::ST_W - 1;
    logic [ST_W_L:0] status_r;
    logic [ST_W_L:0] mask_r;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    function automatic logic [31:0] scale(input logic [15:0] v,
                                          input logic [15:0] k);
        scale = v * k;
    endfunction

    function automatic logic [31:0] bits_per_baud(input logic [2:0] s);
        unique case (s)
            3'h0:    bits_per_baud = 32'd83333;
            3'h1:    bits_per_baud = 32'd41667;
            3'h2:    bits_per_baud = 32'd20833;
            3'h3:    bits_per_baud = 32'd10417;
            3'h4:    bits_per_baud = 32'd5208;
            3'h5:    bits_per_baud = 32'd2604;
            3'h6:    bits_per_baud = 32'd1736;
            default: bits_per_baud = 32'd868;
        endcase
    endfunction

    function automatic logic [7:0] chars_of(input logic [2:0] s);
        unique case (s)
            3'h1:    chars_of = 8'h0a;
            3'h2:    chars_of = 8'h14;
            3'h3:    chars_of = 8'h32;
            3'h4:    chars_of = 8'h64;
            3'h5:    chars_of = 8'hc8;
            default: chars_of = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register writes.
    wire recoveryHit = regWr && regAddr == mbsl_pkg::ADDR_RECOVERY &&
                       regWdata[15:0] == mbsl_pkg::RECOVERY_CODE &&
                       !recoveryUsed_r;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            station_r                    <= mbsl_pkg::STATION_RST;
            baudSel_r                    <= 3'h3;
            remote_config_write_permit_r <= 1'b1;
            threshold_edit_permit_r      <= 4'h0;
            frame_gap_limit_r            <= 7'h00;
            reply_delay_select_r         <= 3'h0;
            flow_scale_factor_r          <= 16'h0001;
            total_scale_factor_r         <= 16'h0001;
            batch_scale_factor_r         <= 16'h0001;
            range420_r                   <= 1'b1;
            mask_r                       <= '0;
        end else if (factoryRestore) begin
            // Mask is kept so that the restore event can still interrupt.
            station_r                    <= mbsl_pkg::STATION_RST;
            baudSel_r                    <= 3'h3;
            remote_config_write_permit_r <= 1'b1;
            threshold_edit_permit_r      <= 4'h0;
            frame_gap_limit_r            <= 7'h00;
            reply_delay_select_r         <= 3'h0;
            flow_scale_factor_r          <= 16'h0001;
            total_scale_factor_r         <= 16'h0001;
            batch_scale_factor_r         <= 16'h0001;
            range420_r                   <= 1'b1;
        end else if (regWr) begin
            unique case (regAddr)
                mbsl_pkg::ADDR_STATION:
                    if (regWdata[7:0] <= mbsl_pkg::STATION_MAX) begin
                        station_r <= regWdata[7:0];
                    end
                mbsl_pkg::ADDR_BAUD:     baudSel_r <= regWdata[2:0];
                mbsl_pkg::ADDR_ACCESS: begin
                    remote_config_write_permit_r <= regWdata[0];
                    threshold_edit_permit_r      <= regWdata[7:4];
                end
                mbsl_pkg::ADDR_GAPLIM:
                    if (regWdata[6:0] <= mbsl_pkg::GAP_MAX) begin
                        frame_gap_limit_r <= regWdata[6:0];
                    end
                mbsl_pkg::ADDR_REPLY:
                    if (regWdata[2:0] <= 3'h5) begin
                        reply_delay_select_r <= regWdata[2:0];
                    end
                mbsl_pkg::ADDR_FLOWCOEF: flow_scale_factor_r  <= regWdata[15:0];
                mbsl_pkg::ADDR_TOTCOEF:  total_scale_factor_r <= regWdata[15:0];
                mbsl_pkg::ADDR_BATCOEF:  batch_scale_factor_r <= regWdata[15:0];
                mbsl_pkg::ADDR_CURRENT:  range420_r <= regWdata[0];
                mbsl_pkg::ADDR_MASK:     mask_r <= regWdata[ST_W_L:0];
                default: ;
            endcase
        end
    end

    // Passcode and single-use recovery.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            user_passcode_r <= mbsl_pkg::PASSCODE_NONE;
            recoveryUsed_r  <= 1'b0;
        end else if (recoveryHit) begin
            user_passcode_r <= mbsl_pkg::PASSCODE_NONE;
            recoveryUsed_r  <= 1'b1;
        end else if (regWr && regAddr == mbsl_pkg::ADDR_PASSCODE &&
                     regWdata[3:0] < 4'ha && regWdata[7:4] < 4'ha &&
                     regWdata[11:8] < 4'ha && regWdata[15:12] < 4'ha) begin
            user_passcode_r <= regWdata[15:0];
        end
    end

    assign passcodeNeeded = user_passcode_r != mbsl_pkg::PASSCODE_NONE;
    assign thresholdEditOpen = threshold_edit_permit_r |
                               {4{!passcodeNeeded}};

    ////////////////////////////////////////////////////////////////////////
    // Factory restore: code arms, confirm restores, cancel abandons.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            restoreArmed_r <= 1'b0;
            factoryRestore <= 1'b0;
        end else begin
            factoryRestore <= restoreArmed_r && keyConfirm;
            if (regWr && regAddr == mbsl_pkg::ADDR_RESTORE &&
                regWdata[15:0] == mbsl_pkg::RESTORE_CODE) begin
                restoreArmed_r <= 1'b1;
            end else if (keyConfirm || keyCancel) begin
                restoreArmed_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame acceptance and write gating.
    logic addrMatch;
    logic writeAllowed;
    always_comb begin
        addrMatch = frameIn.station == station_r ||
                    (station_r == 8'h00 &&
                     frameIn.station == mbsl_pkg::STATION_ALIAS);
        writeAllowed = remote_config_write_permit_r ||
                       frameIn.regIndex == mbsl_pkg::REG_OPEN_A ||
                       frameIn.regIndex == mbsl_pkg::REG_OPEN_B;
    end

    // Bit-time and character-time enables from one divider.
    logic [31:0] bitCnt_r;
    logic [3:0]  charBits_r;
    logic        charTick;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bitCnt_r   <= '0;
            charBits_r <= '0;
        end else if (bitCnt_r >= bits_per_baud(baudSel_r) - 32'd1) begin
            bitCnt_r   <= '0;
            charBits_r <= (charBits_r == 4'(mbsl_pkg::BITS_CHAR - 1)) ?
                          4'h0 : charBits_r + 4'h1;
        end else begin
            bitCnt_r <= bitCnt_r + 32'd1;
        end
    end
    assign baudTick = bitCnt_r == 32'd0;
    assign charTick = baudTick &&
                      charBits_r == 4'(mbsl_pkg::BITS_CHAR - 1);

    ////////////////////////////////////////////////////////////////////////
    // Reply delay.
    logic [7:0]            delayLeft_r;
    logic                  pending_r;
    mbsl_pkg::mbsl_reply_s pendReply_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending_r   <= 1'b0;
            delayLeft_r <= '0;
            pendReply_r <= '0;
            replyOut    <= '0;
            replyValid  <= 1'b0;
        end else begin
            replyValid <= 1'b0;
            if (frameValid && addrMatch) begin
                pending_r            <= 1'b1;
                delayLeft_r          <= chars_of(reply_delay_select_r);
                pendReply_r.accept   <= 1'b1;
                pendReply_r.writeOk  <= !frameIn.isWrite || writeAllowed;
                pendReply_r.regIndex <= frameIn.regIndex;
                pendReply_r.data     <= frameIn.data;
            end else if (pending_r && delayLeft_r == 8'h00) begin
                pending_r  <= 1'b0;
                replyOut   <= pendReply_r;
                replyValid <= 1'b1;
            end else if (pending_r && charTick) begin
                delayLeft_r <= delayLeft_r - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame-gap supervision.
    logic [31:0] secCnt_r;
    logic [6:0]  gapSec_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            secCnt_r    <= '0;
            gapSec_r    <= '0;
            remoteAlert <= 1'b0;
        end else if (frameValid || frame_gap_limit_r == 7'h00) begin
            secCnt_r    <= '0;
            gapSec_r    <= '0;
            remoteAlert <= 1'b0;
        end else if (secCnt_r == 32'(mbsl_pkg::SECOND_CYC - 1)) begin
            secCnt_r <= '0;
            if (gapSec_r >= frame_gap_limit_r) begin
                remoteAlert <= 1'b1;
            end else begin
                gapSec_r <= gapSec_r + 7'h01;
            end
        end else begin
            secCnt_r <= secCnt_r + 32'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unit scaling and input normalization; measuredValue is in uA.
    logic signed [31:0] norm_r;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flowScaled  <= '0;
            totalScaled <= '0;
            batchScaled <= '0;
            norm_r      <= '0;
        end else begin
            flowScaled  <= scale(measuredValue, flow_scale_factor_r);
            totalScaled <= scale(measuredValue, total_scale_factor_r);
            batchScaled <= scale(measuredValue, batch_scale_factor_r);
            // Fixed point Q16; no clamp, so under- and over-range pass.
            if (range420_r) begin
                norm_r <= ((signed'(32'(measuredValue)) - 32'sd4000) <<< 16) /
                          32'sd16000;
            end else begin
                norm_r <= (32'(measuredValue) <<< 16) / 32'sd20000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, set wins over write-one-to-clear.
    logic [ST_W_L:0] events;
    always_comb begin
        events = '0;
        events[mbsl_pkg::ST_FRAME]   = frameValid && addrMatch;
        events[mbsl_pkg::ST_ALERT]   = remoteAlert;
        events[mbsl_pkg::ST_REFUSED] = frameValid && addrMatch &&
                                       frameIn.isWrite && !writeAllowed;
        events[mbsl_pkg::ST_RESTORE] = factoryRestore;
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~((regWr &&
                        regAddr == mbsl_pkg::ADDR_STATUS) ?
                        regWdata[ST_W_L:0] : '0)) | events;
        end
    end
    assign irq = |(status_r & mask_r);

    // Read port, data one cycle later.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                mbsl_pkg::ADDR_STATION:  regRdata <= {24'h0, station_r};
                mbsl_pkg::ADDR_BAUD:     regRdata <= {29'h0, baudSel_r};
                mbsl_pkg::ADDR_ACCESS:   regRdata <= {24'h0,
                    threshold_edit_permit_r, 3'h0,
                    remote_config_write_permit_r};
                mbsl_pkg::ADDR_GAPLIM:   regRdata <= {25'h0, frame_gap_limit_r};
                mbsl_pkg::ADDR_REPLY:    regRdata <= {29'h0,
                                                      reply_delay_select_r};
                mbsl_pkg::ADDR_PASSCODE: regRdata <= {16'h0, user_passcode_r};
                mbsl_pkg::ADDR_RECOVERY: regRdata <= {31'h0, recoveryUsed_r};
                mbsl_pkg::ADDR_RESTORE:  regRdata <= {31'h0, restoreArmed_r};
                mbsl_pkg::ADDR_FLOWCOEF: regRdata <= {16'h0, flow_scale_factor_r};
                mbsl_pkg::ADDR_TOTCOEF:  regRdata <= {16'h0, total_scale_factor_r};
                mbsl_pkg::ADDR_BATCOEF:  regRdata <= {16'h0, batch_scale_factor_r};
                mbsl_pkg::ADDR_CURRENT:  regRdata <= {31'h0, range420_r};
                mbsl_pkg::ADDR_STATUS:   regRdata <= {28'h0, status_r};
                mbsl_pkg::ADDR_MASK:     regRdata <= {28'h0, mask_r};
                mbsl_pkg::ADDR_NORM:     regRdata <= norm_r;
                mbsl_pkg::ADDR_ALERT:    regRdata <= {31'h0, remoteAlert};
                default:                 regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    station_range_a: assert property (
        station_r <= mbsl_pkg::STATION_MAX)
        else $error("station out of range");
    alias_accept_a: assert property (
        frameValid && station_r == 8'h00 && frameIn.station == 8'hff
        |=> pending_r) else $error("alias frame ignored");
    write_refuse_a: assert property (
        frameValid && addrMatch && frameIn.isWrite &&
        !remote_config_write_permit_r && frameIn.regIndex > 16'h0005
        |=> !pendReply_r.writeOk) else $error("write not refused");
    open_regs_a: assert property (
        frameValid && addrMatch && frameIn.regIndex == 16'h0004
        |=> pendReply_r.writeOk) else $error("open register refused");
    gap_off_a: assert property (
        frame_gap_limit_r == 7'h00 |=> !remoteAlert)
        else $error("alert with gap check off");
    gap_release_a: assert property (
        frameValid |=> !remoteAlert) else $error("alert not released");
    recovery_once_a: assert property (
        recoveryHit |=> user_passcode_r == 16'h0000 && recoveryUsed_r)
        else $error("recovery failed");
    restore_cancel_a: assert property (
        restoreArmed_r && keyCancel && !keyConfirm |=> ##1 !factoryRestore)
        else $error("restore after cancel");
    std_reply_a: assert property (
        frameValid && addrMatch && reply_delay_select_r == 3'h0
        ##1 !(frameValid && addrMatch) |=> replyValid)
        else $error("no-delay reply late");

endmodule

// ---- sim/mbsl_master_model.sv ----
// Bus master on the far side: sends one whole frame at a time, then
// listens a bounded while for the reply.
module mbsl_master_model (
    input  wire logic                  core_clk,
    output logic                       frameValid,
    output mbsl_pkg::mbsl_frame_s      frameIn,
    input  wire logic                  replyValid,
    input  wire mbsl_pkg::mbsl_reply_s replyOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial frameValid = 1'b0;
    initial frameIn = '0;
    // The master runs at the device rate and keeps no extra delay.
    task automatic send(input logic [7:0] st, input logic [15:0] idx,
                        output logic got, output mbsl_pkg::mbsl_reply_s rep);
        got = 1'b0;
        rep = '0;
        @(posedge core_clk);
        frameValid <= 1'b1;
        frameIn <= '{st, 1'b1, idx, 16'h00a5};
        @(posedge core_clk);
        frameValid <= 1'b0;
        // Released fields flip so that stale values never look valid.
        frameIn <= ~frameIn;
        repeat (8) begin
            @(posedge core_clk);
            #1;
            if (replyValid === 1'b1 && !got) begin
                got = 1'b1;
                rep = replyOut;
            end
        end
    endtask
endmodule

// ---- sim/test_mbsl_link_supervisor.sv ----
module test_mbsl_link_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} mbsl_row_s;
    logic                  core_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic [7:0]            regAddr = 8'h00;
    logic [31:0]           regWdata = 32'h0;
    logic                  regWr = 1'b0;
    logic                  regRd = 1'b0;
    logic                  keyConfirm = 1'b0;
    logic                  keyCancel = 1'b0;
    logic [15:0]           measuredValue = 16'h2710;
    logic [31:0]           regRdata, flowScaled, totalScaled, batchScaled;
    logic                  frameValid, replyValid, baudTick, remoteAlert;
    logic                  passcodeNeeded, factoryRestore, irq, got;
    logic [3:0]            thresholdEditOpen;
    mbsl_pkg::mbsl_frame_s frameIn;
    mbsl_pkg::mbsl_reply_s replyOut, rep;
    int                    n_fail = 0;
    int                    cmp_count = 0;
    int                    nRestore = 0;
    int                    nTick = 0;
    mbsl_row_s rows [8] = '{
        '{8'h00, 32'hc7, 32'hc7}, '{8'h00, 32'hc8, 32'hc7},
        '{8'h0c, 32'h63, 32'h63}, '{8'h0c, 32'h64, 32'h63},
        '{8'h10, 32'h5, 32'h5}, '{8'h10, 32'h6, 32'h5},
        '{8'h0c, 32'h0, 32'h0}, '{8'h14, 32'h12a4, 32'h0}};
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (factoryRestore === 1'b1) nRestore++;
    mbsl_link_supervisor dut (.core_clk, .sys_rst, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .frameValid, .frameIn, .replyOut,
        .replyValid, .baudTick, .remoteAlert, .passcodeNeeded,
        .thresholdEditOpen, .factoryRestore, .keyConfirm, .keyCancel,
        .measuredValue, .flowScaled, .totalScaled, .batchScaled, .irq);
    mbsl_master_model master (.core_clk, .frameValid, .frameIn,
        .replyValid, .replyOut);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask
    task automatic key(input logic conf);
        @(posedge core_clk);
        keyConfirm <= conf;
        keyCancel <= !conf;
        @(posedge core_clk);
        keyConfirm <= 1'b0;
        keyCancel <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        n_fail++;
        summarize;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(mbsl_pkg::ADDR_STATION, 32'h1);
        rd(mbsl_pkg::ADDR_BAUD, 32'h3);
        rd(mbsl_pkg::ADDR_GAPLIM, 32'h0);
        chk(32'(passcodeNeeded), 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        for (int b = 0; b < 8; b++) begin
            wr(mbsl_pkg::ADDR_BAUD, 32'(b));
            rd(mbsl_pkg::ADDR_BAUD, 32'(b));
        end
        $display("test table done");
        wr(mbsl_pkg::ADDR_STATION, 32'h5);
        wr(mbsl_pkg::ADDR_REPLY, 32'h1);
        master.send(8'h05, 16'h0000, got, rep);
        chk(32'(got), 32'h0);
        wr(mbsl_pkg::ADDR_REPLY, 32'h0);
        master.send(8'h05, 16'h0000, got, rep);
        chk({got, rep.accept, rep.writeOk}, 32'h7);
        master.send(8'h06, 16'h0000, got, rep);
        chk(32'(got), 32'h0);
        wr(mbsl_pkg::ADDR_STATION, 32'h0);
        wr(mbsl_pkg::ADDR_ACCESS, 32'h0);
        wr(mbsl_pkg::ADDR_STATUS, 32'hf);
        master.send(8'hff, 16'h0000, got, rep);
        chk({got, rep.accept, rep.writeOk}, 32'h6);
        master.send(8'hff, 16'h0004, got, rep);
        chk({got, rep.writeOk}, 32'h3);
        master.send(8'hff, 16'h0005, got, rep);
        chk({got, rep.writeOk}, 32'h3);
        master.send(8'hff, 16'h0010, got, rep);
        chk({got, rep.writeOk}, 32'h2);
        chk(32'(remoteAlert), 32'h0);
        rd(mbsl_pkg::ADDR_STATUS, 32'h5);
        wr(mbsl_pkg::ADDR_MASK, 32'h4);
        chk(32'(irq), 32'h1);
        wr(mbsl_pkg::ADDR_STATUS, 32'h4);
        chk(32'(irq), 32'h0);
        $display("test link done");
        repeat (1736) begin
            @(posedge core_clk);
            if (baudTick === 1'b1) nTick++;
        end
        chk(32'(nTick), 32'h2);
        wr(mbsl_pkg::ADDR_PASSCODE, 32'h1234);
        chk(32'(passcodeNeeded), 32'h1);
        wr(mbsl_pkg::ADDR_ACCESS, 32'h50);
        chk(32'(thresholdEditOpen), 32'h5);
        wr(mbsl_pkg::ADDR_RECOVERY, 32'h7391);
        rd(mbsl_pkg::ADDR_PASSCODE, 32'h0);
        rd(mbsl_pkg::ADDR_RECOVERY, 32'h1);
        wr(mbsl_pkg::ADDR_PASSCODE, 32'h1234);
        wr(mbsl_pkg::ADDR_RECOVERY, 32'h7391);
        rd(mbsl_pkg::ADDR_PASSCODE, 32'h1234);
        $display("test passcode done");
        // A value outside the nominal range must keep its sign.
        wr(mbsl_pkg::ADDR_CURRENT, 32'h1);
        repeat (4) @(posedge core_clk);
        rd(mbsl_pkg::ADDR_NORM, 32'h6000);
        @(posedge core_clk) measuredValue <= 16'h09c4;
        repeat (4) @(posedge core_clk);
        rd(mbsl_pkg::ADDR_NORM, 32'hffffe800);
        @(posedge core_clk) measuredValue <= 16'h2710;
        wr(mbsl_pkg::ADDR_CURRENT, 32'h0);
        repeat (4) @(posedge core_clk);
        rd(mbsl_pkg::ADDR_NORM, 32'h8000);
        wr(mbsl_pkg::ADDR_FLOWCOEF, 32'h2);
        wr(mbsl_pkg::ADDR_TOTCOEF, 32'h3);
        wr(mbsl_pkg::ADDR_BATCOEF, 32'h4);
        @(posedge core_clk);
        #1;
        chk(flowScaled, 32'h4e20);
        chk(totalScaled, 32'h7530);
        chk(batchScaled, 32'h9c40);
        $display("test normalize done");
        wr(mbsl_pkg::ADDR_RESTORE, 32'h5465);
        key(1'b0);
        key(1'b1);
        chk(32'(nRestore), 32'h0);
        wr(mbsl_pkg::ADDR_RESTORE, 32'h5465);
        key(1'b1);
        chk(32'(nRestore), 32'h1);
        rd(mbsl_pkg::ADDR_STATION, 32'h1);
        rd(mbsl_pkg::ADDR_STATUS, 32'h9);
        $display("test restore done");
        summarize;
    end
endmodule
